// ---- rtl/lsns_cfg.svh ----
// Purpose: constants for the line sensing status register bank
// Assumes: word index registers, byte address is four times the index
// Notes:   threshold counts derive from millivolts and the converter lsb
`ifndef LSNS_CFG_SVH
`define LSNS_CFG_SVH

// register indices
`define LSNS_IDX_STATUS    8'h03
`define LSNS_IDX_IRQ_EN    8'h05
`define LSNS_IDX_RING_TH   8'h0E
`define LSNS_IDX_DET_CTRL  8'h12
`define LSNS_IDX_DET_EN    8'h15
`define LSNS_IDX_RING_V    8'h1A
`define LSNS_IDX_LINE_V    8'h1B
`define LSNS_IDX_LOOP_I    8'h1C
`define LSNS_IDX_DET_STAT  8'h1E

// field positions
`define LSNS_BIT_RING_EV   0
`define LSNS_BIT_FAULT     2
`define LSNS_BIT_RING_LIVE 3
`define LSNS_BIT_RING_IEN  0
`define LSNS_BIT_FAULT_IEN 2
`define LSNS_BIT_MASTER_EN 1
`define LSNS_BIT_UV_EN     2
`define LSNS_BIT_UV_SEEN   6

// reset values
`define LSNS_RST_RING_IEN  1'b1
`define LSNS_RST_FAULT_IEN 1'b0
`define LSNS_RST_MASTER_EN 1'b0
`define LSNS_RST_UV_EN     1'b0
`define LSNS_RST_RING_TH   2'h0

// ring threshold figures
`define LSNS_RING_LSB_UV   10230
`define LSNS_RING_TH1_MV   150
`define LSNS_RING_TH2_MV   300
`define LSNS_RING_TH3_MV   450
`define LSNS_RING_TH1_CNT  ((`LSNS_RING_TH1_MV * 1000) / `LSNS_RING_LSB_UV)
`define LSNS_RING_TH2_CNT  ((`LSNS_RING_TH2_MV * 1000) / `LSNS_RING_LSB_UV)
`define LSNS_RING_TH3_CNT  ((`LSNS_RING_TH3_MV * 1000) / `LSNS_RING_LSB_UV)

`endif

// ---- rtl/lsns_pkg.sv ----
// Purpose: types for the line sensing status register bank
// Assumes: nothing
// Notes:   one-hot bus states, converter channel codes
package lsns_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } lsns_bus_st_t;

  typedef enum logic [1:0] {
    ADC_RING = 2'h0,
    ADC_LINE = 2'h1,
    ADC_LOOP = 2'h2
  } lsns_adc_ch_t;

endpackage

// ---- rtl/lsns_sync.sv ----
// Purpose: two flip-flop synchroniser for asynchronous levels
// Assumes: inputs are slow levels
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module lsns_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  initial begin
    if (WIDTH < 1) begin
      $error("lsns_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/lsns_regs.sv ----
// Purpose: line sensing control and status registers on classic Wishbone
// Assumes: converter samples arrive on sys_clk; fault levels are async
// Notes:   one wait state on every access, reads of status clear flags
`include "lsns_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module lsns_regs
  import lsns_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  // auxiliary converter results
  input  wire logic              adcValid,
  input  wire logic [1:0]        adcChannel,
  input  wire logic [7:0]        adcData,
  // line side conditions, asynchronous levels
  input  wire logic              undervoltCondition,
  input  wire logic              overvoltCondition,
  input  wire logic              overcurrentCondition,
  // power mode strap from same clock
  input  wire logic              linePoweredMode,
  // line side actions
  output logic                   loopBandwidthWide,
  output logic                   autoOnHook,
  output logic                   barrierPowerSelect,
  // host interrupt
  output logic                   hostIrq
);

  initial begin
    if (DATA_W != 32) begin
      $error("lsns_regs: DATA_W must be 32");
    end
    if (ADDR_W < 7) begin
      $error("lsns_regs: ADDR_W must be at least 7");
    end
    if (`LSNS_RING_TH3_CNT > 127) begin
      $error("lsns_regs: ring threshold count exceeds seven bits");
    end
    if (`LSNS_RING_TH1_CNT >= `LSNS_RING_TH2_CNT ||
        `LSNS_RING_TH2_CNT >= `LSNS_RING_TH3_CNT) begin
      $error("lsns_regs: ring threshold counts must rise with the code");
    end
    if (`LSNS_BIT_RING_LIVE > 7 || `LSNS_BIT_UV_SEEN > 7) begin
      $error("lsns_regs: status fields must sit in the low byte");
    end
  end

  // ones-complement sample to magnitude
  function automatic logic [6:0] ones_mag(input logic [7:0] s);
    ones_mag = s[7] ? ~s[6:0] : s[6:0];
  endfunction

  // threshold code to count, zero means disabled
  function automatic logic [6:0] ring_th_cnt(input logic [1:0] sel);
    case (sel)
      2'h1:    ring_th_cnt = 7'(`LSNS_RING_TH1_CNT);
      2'h2:    ring_th_cnt = 7'(`LSNS_RING_TH2_CNT);
      2'h3:    ring_th_cnt = 7'(`LSNS_RING_TH3_CNT);
      default: ring_th_cnt = 7'h7F;
    endcase
  endfunction

  // word index decode
  function automatic logic idx_is(input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        idx);
    idx_is = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  lsns_bus_st_t     busSt_q;
  logic             req;
  logic             rdReq;
  logic             wrReq;
  logic             wrLow;
  logic             statusRd;
  logic [7:0]       rdByte;
  logic [2:0]       condSync;
  logic             uvLive;
  logic             ovLive;
  logic             ocLive;
  logic             faultLive;
  logic             ringSample;
  logic             ringAbove;
  logic [1:0]       ringThSel_q;
  logic             ringIrqEn_q;
  logic             faultIrqEn_q;
  logic             masterEn_q;
  logic             uvEn_q;
  logic             ringLive_q;
  logic             ringEvent_q;
  logic             faultFlag_q;
  logic             uvSeen_q;
  logic [7:0]       ringVolt_q;
  logic [6:0]       lineVolt_q;
  logic [6:0]       loopCur_q;
  logic             barrier_q;

  lsns_sync #(
    .WIDTH (3)
  ) u_cond_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .asyncIn ({overcurrentCondition, overvoltCondition,
               undervoltCondition}),
    .syncOut (condSync)
  );

  // bus request decode
  assign req      = wb_cyc_i && wb_stb_i && (busSt_q == BUS_IDLE);
  assign rdReq    = req && !wb_we_i;
  assign wrReq    = req && wb_we_i;
  assign wrLow    = wrReq && wb_sel_i[0];
  assign statusRd = rdReq && idx_is(wb_adr_i, `LSNS_IDX_STATUS);

  // conditions gated by the master enable
  // ov and oc have no enables of their own here
  assign uvLive    = masterEn_q && uvEn_q && condSync[0];
  assign ovLive    = masterEn_q && condSync[1];
  assign ocLive    = masterEn_q && condSync[2];
  assign faultLive = uvLive || ovLive || ocLive;

  // ring comparison on each ring sample
  assign ringSample = adcValid && (adcChannel == ADC_RING);
  assign ringAbove  = (ringThSel_q != 2'h0) &&
                      (ones_mag(adcData) > ring_th_cnt(ringThSel_q));

  // bus handshake, one wait state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busSt_q <= BUS_IDLE;
    end else begin
      case (busSt_q)
        BUS_IDLE: begin
          if (wb_cyc_i && wb_stb_i) begin
            busSt_q <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          busSt_q <= BUS_IDLE;
        end
        default: begin
          busSt_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // a held stb after ack opens a new access
  assign wb_ack_o = (busSt_q == BUS_ACK);

  // read mux
  always_comb begin
    rdByte = 8'h00;
    if (idx_is(wb_adr_i, `LSNS_IDX_STATUS)) begin
      rdByte[`LSNS_BIT_RING_EV]   = ringEvent_q;
      rdByte[`LSNS_BIT_FAULT]     = faultFlag_q;
      rdByte[`LSNS_BIT_RING_LIVE] = ringLive_q;
    end else if (idx_is(wb_adr_i, `LSNS_IDX_IRQ_EN)) begin
      rdByte[`LSNS_BIT_RING_IEN]  = ringIrqEn_q;
      rdByte[`LSNS_BIT_FAULT_IEN] = faultIrqEn_q;
    end else if (idx_is(wb_adr_i, `LSNS_IDX_RING_TH)) begin
      rdByte[1:0] = ringThSel_q;
    end else if (idx_is(wb_adr_i, `LSNS_IDX_RING_V)) begin
      rdByte = ringVolt_q;
    end else if (idx_is(wb_adr_i, `LSNS_IDX_LINE_V)) begin
      rdByte[7:1] = lineVolt_q;
    end else if (idx_is(wb_adr_i, `LSNS_IDX_LOOP_I)) begin
      rdByte[7:1] = loopCur_q;
    end else if (idx_is(wb_adr_i, `LSNS_IDX_DET_STAT)) begin
      rdByte[`LSNS_BIT_UV_SEEN] = uvSeen_q;
    end
  end

  // read data captured with the request
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= '0;
    end else if (rdReq) begin
      wb_dat_o <= {{(DATA_W-8){1'b0}}, rdByte};
    end
  end

  // ring threshold select
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ringThSel_q <= `LSNS_RST_RING_TH;
    end else if (wrLow && idx_is(wb_adr_i, `LSNS_IDX_RING_TH)) begin
      ringThSel_q <= wb_dat_i[1:0];
    end
  end

  // interrupt enables
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ringIrqEn_q  <= `LSNS_RST_RING_IEN;
      faultIrqEn_q <= `LSNS_RST_FAULT_IEN;
    end else if (wrLow && idx_is(wb_adr_i, `LSNS_IDX_IRQ_EN)) begin
      ringIrqEn_q  <= wb_dat_i[`LSNS_BIT_RING_IEN];
      faultIrqEn_q <= wb_dat_i[`LSNS_BIT_FAULT_IEN];
    end
  end

  // detector enables, write only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      masterEn_q <= `LSNS_RST_MASTER_EN;
      uvEn_q     <= `LSNS_RST_UV_EN;
    end else begin
      if (wrLow && idx_is(wb_adr_i, `LSNS_IDX_DET_CTRL)) begin
        masterEn_q <= wb_dat_i[`LSNS_BIT_MASTER_EN];
      end
      if (wrLow && idx_is(wb_adr_i, `LSNS_IDX_DET_EN)) begin
        uvEn_q <= wb_dat_i[`LSNS_BIT_UV_EN];
      end
    end
  end

  // live ringing, refreshed per sample
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ringLive_q <= 1'b0;
    end else if (ringSample) begin
      ringLive_q <= ringAbove;
    end else if (statusRd) begin
      ringLive_q <= 1'b0;
    end
  end

  // latched ring or reversal event
  // a ring sample above threshold in the read cycle keeps the flag set
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ringEvent_q <= 1'b0;
    end else if (ringSample && ringAbove) begin
      ringEvent_q <= 1'b1;
    end else if (statusRd) begin
      ringEvent_q <= 1'b0;
    end
  end

  // voltage or current fault flag
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      faultFlag_q <= 1'b0;
    end else if (faultLive) begin
      faultFlag_q <= 1'b1;
    end else if (statusRd) begin
      faultFlag_q <= 1'b0;
    end
  end

  // under-voltage status, unlatched
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      uvSeen_q <= 1'b0;
    end else begin
      uvSeen_q <= uvLive;
    end
  end

  // converter result capture
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ringVolt_q <= 8'h00;
      lineVolt_q <= 7'h00;
      loopCur_q  <= 7'h00;
    end else if (adcValid) begin
      case (adcChannel)
        ADC_RING: ringVolt_q <= adcData;
        ADC_LINE: lineVolt_q <= adcData[7:1];
        ADC_LOOP: loopCur_q  <= adcData[6:0];
        // channel three carries no result
        default:  ringVolt_q <= ringVolt_q;
      endcase
    end
  end

  // line side actions
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      loopBandwidthWide <= 1'b0;
      autoOnHook        <= 1'b0;
    end else begin
      loopBandwidthWide <= uvLive;
      autoOnHook        <= ovLive || ocLive;
    end
  end

  // barrier power hold while line powered
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      barrier_q <= 1'b0;
    end else if (!linePoweredMode) begin
      barrier_q <= 1'b0;
    end else if (uvLive) begin
      barrier_q <= 1'b1;
    end
  end

  assign barrierPowerSelect = barrier_q;

  // host interrupt
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hostIrq <= 1'b0;
    end else begin
      hostIrq <= (ringEvent_q && ringIrqEn_q) ||
                 (faultFlag_q && faultIrqEn_q);
    end
  end

endmodule
`default_nettype wire

// ---- bench/lsns_regs_assertions.sv ----
// Purpose: bus, fault and interrupt timing checks
// Assumes: bound onto lsns_regs
// Notes:   quiet conditions for four cycles imply idle on-hook and bandwidth outputs
`timescale 1ns/1ps
`default_nettype none
module lsns_regs_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // line side
  input wire logic        adcValid,
  input wire logic        undervoltCondition,
  input wire logic        overvoltCondition,
  input wire logic        overcurrentCondition,
  input wire logic        linePoweredMode,
  input wire logic        loopBandwidthWide,
  input wire logic        autoOnHook,
  input wire logic        barrierPowerSelect,
  input wire logic        hostIrq
);
  logic [3:0] calmQ;
  logic       req;
  logic       rdStat;
  logic       calm;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rdStat = req && !wb_we_i && wb_adr_i == 8'h0C && !adcValid;
  assign calm   = !(undervoltCondition || overvoltCondition ||
                    overcurrentCondition);

  // last four sampled condition levels all quiet
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      calmQ <= 4'h0;
    else
      calmQ <= {calmQ[2:0], calm};
  end

  ack_late_a: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  onhook_calm_a: assert property (
    (!overvoltCondition && !overcurrentCondition)[*4] |=> !autoOnHook)
    else $error("on-hook without a condition");
  wide_calm_a: assert property (
    (!undervoltCondition)[*4] |=> !loopBandwidthWide)
    else $error("wide bandwidth without under-voltage");
  barrier_off_a: assert property (
    !linePoweredMode |=> !barrierPowerSelect)
    else $error("barrier power while not line powered");
  barrier_keep_a: assert property (
    barrierPowerSelect && linePoweredMode |=> barrierPowerSelect)
    else $error("barrier power dropped early");
  irq_clear_a: assert property (
    rdStat && &calmQ |-> ##2 !hostIrq)
    else $error("interrupt stays after status read");

  cover property (rdStat);
  cover property ($rose(hostIrq));
  cover property ($rose(autoOnHook));
  cover property ($rose(barrierPowerSelect));
endmodule

bind lsns_regs lsns_regs_chk chk_u (.sys_clk, .resetn, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .adcValid,
  .undervoltCondition, .overvoltCondition, .overcurrentCondition,
  .linePoweredMode, .loopBandwidthWide, .autoOnHook,
  .barrierPowerSelect, .hostIrq);
`default_nettype wire

// ---- bench/lsns_line_model.sv ----
// Purpose: converter sample source standing for the line side
// Assumes: bench holds go and data for one cycle
// Notes:   idle result bus shows the inverse of the held value
`timescale 1ns/1ps
`default_nettype none
module lsns_line_model (
  // request
  input  wire logic       go,
  input  wire logic [1:0] ch,
  input  wire logic [7:0] d,
  // converter result
  output logic            adcValid,
  output logic      [1:0] adcChannel,
  output logic      [7:0] adcData
);
  assign adcValid   = go;
  assign adcChannel = go ? ch : ~ch;
  assign adcData    = go ? d : ~d;
endmodule
`default_nettype wire

// ---- bench/line_sense_status_regs_tb.sv ----
// Purpose: random and corner tests of the line sensing registers
// Assumes: one wait state bus, 20 MHz clock
// Notes:   ring counts reckoned from millivolts and lsb weight
`timescale 1ns/1ps
`default_nettype none
module line_sense_status_regs_tb;
  logic        sys_clk;
  logic        resetn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        go;
  logic [1:0]  ch;
  logic [7:0]  d;
  logic        adcValid;
  logic [1:0]  adcChannel;
  logic [7:0]  adcData;
  logic        uv;
  logic        ov;
  logic        oc;
  logic        linePwr;
  logic        bwWide;
  logic        onHook;
  logic        barrier;
  logic        hostIrq;
  int          numErrors;
  int          nCompared;
  int          seed;
  logic [31:0] v;
  logic [7:0]  s;
  logic [1:0]  code;
  logic [7:0]  corner [4] = '{8'h7F, 8'h0F, 8'hE2, 8'h2C};

  lsns_regs dut_u (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .adcValid(adcValid), .adcChannel(adcChannel), .adcData(adcData),
    .undervoltCondition(uv), .overvoltCondition(ov),
    .overcurrentCondition(oc), .linePoweredMode(linePwr),
    .loopBandwidthWide(bwWide), .autoOnHook(onHook),
    .barrierPowerSelect(barrier), .hostIrq(hostIrq));
  lsns_line_model line_u (.go(go), .ch(ch), .d(d), .adcValid(adcValid),
    .adcChannel(adcChannel), .adcData(adcData));

  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic tallyAndFinish();
    $display("compared %0d errors %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e) begin
      numErrors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] x, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= x;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (n >= 20)
      numErrors++;
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    bus(1'h1, a, x, r);
  endtask

  task automatic chkRd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'h0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic smp(input logic [1:0] c, input logic [7:0] x);
    @(posedge sys_clk);
    go <= 1'h1;
    ch <= c;
    d <= x;
    @(posedge sys_clk);
    go <= 1'h0;
  endtask

  // ring event expected from code and ones-complement sample
  function automatic logic ringEv(input logic [1:0] c, input logic [7:0] x);
    logic [6:0] m;
    m = x[7] ? ~x[6:0] : x[6:0];
    return c != 2'h0 && int'(m) > int'(c) * 150000 / 10230;
  endfunction

  initial begin
    seed = 32'hbefa356d;
    numErrors = 0;
    nCompared = 0;
    {cyc, stb, we, go, uv, ov, oc, linePwr, resetn} = '0;
    {adr, wdat, ch, d} = '0;
    sel = 4'h1;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'h1;
    chkRd(8'h14, 32'h01);
    chkRd(8'h0C, 32'h00);
    chkRd(8'h48, 32'h00);
    chkRd(8'h78, 32'h00);
    chkRd(8'h40, 32'h00);
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      code = (i < 4) ? i[1:0] : v[1:0];
      s = (i < 4) ? corner[i] : v[9:2];
      wr(8'h38, {30'h0, code});
      chkRd(8'h38, {30'h0, code});
      smp(2'h0, s);
      chkRd(8'h0C, ringEv(code, s) ? 32'h09 : 32'h00);
      chkRd(8'h0C, 32'h00);
    end
    wr(8'h38, 32'h1);
    smp(2'h0, 8'h40);
    repeat (3) @(posedge sys_clk);
    chk(hostIrq, 32'h1);
    chkRd(8'h0C, 32'h09);
    repeat (2) @(posedge sys_clk);
    chk(hostIrq, 32'h0);
    wr(8'h14, 32'h0);
    smp(2'h0, 8'h40);
    repeat (3) @(posedge sys_clk);
    chk(hostIrq, 32'h0);
    chkRd(8'h0C, 32'h09);
    fork
      smp(2'h0, 8'h40);
      bus(1'h0, 8'h0C, 32'h0, v);
    join
    chk(v, 32'h00);
    chkRd(8'h0C, 32'h09);
    $display("ring test done");
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      smp(2'h0, v[7:0]);
      chkRd(8'h68, {24'h0, v[7:0]});
      smp(2'h1, v[7:0]);
      chkRd(8'h6C, {24'h0, v[7:1], 1'h0});
      smp(2'h2, v[7:0]);
      chkRd(8'h70, {24'h0, v[6:0], 1'h0});
    end
    smp(2'h3, ~v[7:0]);
    chkRd(8'h68, {24'h0, v[7:0]});
    wr(8'h6C, 32'h0);
    chkRd(8'h6C, {24'h0, v[7:1], 1'h0});
    sel <= 4'h0;
    wr(8'h14, 32'h4);
    sel <= 4'h1;
    chkRd(8'h14, 32'h0);
    $display("sample test done");
    bus(1'h0, 8'h0C, 32'h0, v);
    wr(8'h14, 32'h4);
    ov <= 1'h1;
    repeat (6) @(posedge sys_clk);
    chk({onHook, hostIrq}, 32'h0);
    chkRd(8'h0C, 32'h00);
    wr(8'h48, 32'h2);
    repeat (6) @(posedge sys_clk);
    chk({onHook, hostIrq}, 32'h3);
    ov <= 1'h0;
    oc <= 1'h1;
    repeat (6) @(posedge sys_clk);
    chk(onHook, 32'h1);
    oc <= 1'h0;
    repeat (6) @(posedge sys_clk);
    chk(onHook, 32'h0);
    chkRd(8'h0C, 32'h04);
    chkRd(8'h0C, 32'h00);
    uv <= 1'h1;
    linePwr <= 1'h1;
    repeat (6) @(posedge sys_clk);
    chk({bwWide, barrier}, 32'h0);
    wr(8'h54, 32'h4);
    repeat (6) @(posedge sys_clk);
    chk({bwWide, barrier}, 32'h3);
    chkRd(8'h78, 32'h40);
    uv <= 1'h0;
    repeat (6) @(posedge sys_clk);
    chk({bwWide, barrier}, 32'h1);
    chkRd(8'h78, 32'h00);
    linePwr <= 1'h0;
    repeat (3) @(posedge sys_clk);
    chk(barrier, 32'h0);
    chkRd(8'h0C, 32'h04);
    $display("fault test done");
    tallyAndFinish();
  end

  initial begin
    #500000;
    numErrors++;
    tallyAndFinish();
  end
endmodule
`default_nettype wire
